// [common/typec_ctrl_defines.svh]
// Purpose: field values and timing counts for the connector control block
// Assumes: 250 MHz core clock
// Notes:   definitions only
`ifndef TYPEC_CTRL_DEFINES_SVH
`define TYPEC_CTRL_DEFINES_SVH

// core clock period in ps
`define CLK_PERIOD_PS      32'd4000
// dual-role toggle half period in us, and its cycle count
`define DRP_HALF_US        32'd35
`define DRP_HALF_CYC       (`DRP_HALF_US * 32'd1000000 / `CLK_PERIOD_PS)
// scheme change quiet time in ns, all sources released
`define SWITCH_GAP_NS      32'd1000
`define SWITCH_GAP_CYC     ((`SWITCH_GAP_NS * 32'd1000 + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
// adc code for the 0.6 V level on the positive data line
`define DP_HIGH_CODE       10'h0ba
// strap code boundaries for the wait-for-external-3.3V and safe start-up options
`define STRAP_WAIT_LO      10'h300
`define STRAP_WAIT_HI      10'h3ff
`define STRAP_SAFE_HI      10'h0ff

`endif

// [common/typec_ctrl_pkg.sv]
// Purpose: shared types for the connector control block
// Assumes: nothing
// Notes:   constants live in the defines header
package typec_ctrl_pkg;

  // role requested for the port
  typedef enum logic [1:0] {ROLE_SINK, ROLE_SOURCE, ROLE_DUAL} port_role_t;

  // data line scheme requested by firmware
  typedef enum logic [2:0] {
    SCH_OFF, SCH_CONTACT, SCH_PRIMARY, SCH_SECONDARY,
    SCH_CDP, SCH_DCP, SCH_DIV27, SCH_V12
  } line_scheme_t;

  // start-up behaviour decoded from the strap
  typedef enum logic [1:0] {BOOT_SAFE, BOOT_NORMAL, BOOT_WAIT_EXT} boot_mode_t;

  // analog controls of one config channel pin
  typedef struct packed {
    logic pull_up;
    logic trimmed_sink_pulldown;
    logic deadbatt_sink_pulldown;
    logic swap_signal_pulldown;
  } cc_ctrl_t;

  // analog controls of the data lines
  typedef struct packed {
    logic dplus_contact_source;
    logic dminus_contact_pulldown;
    logic line_voltage_source;
    logic source_on_dminus;
    logic line_current_sink;
    logic line_short_resistor;
    logic divider_both;
    logic v12_on_dminus;
  } line_ctrl_t;

endpackage

// [hdl/line_scheme_driver.sv]
// Purpose: drives the data line analog controls for one scheme at a time
// Assumes: scheme input already gapped by the caller
// Notes:   all controls registered
`timescale 1ns/10ps
`default_nettype none
`include "typec_ctrl_defines.svh"

module line_scheme_driver
(
  // clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  // scheme and line sense
  input  wire typec_ctrl_pkg::line_scheme_t scheme_i,
  input  wire logic [9:0]                  dplus_code_i,
  // analog controls
  output typec_ctrl_pkg::line_ctrl_t       line_o,
  output logic                             cdp_answer_o
);
  import typec_ctrl_pkg::*;

  logic       dp_high;
  logic       cdp_answer;
  line_ctrl_t next_line;

  assign dp_high = (dplus_code_i >= `DP_HIGH_CODE);

  // one decode, so only one scheme drives at a time
  always_comb
  begin
    next_line = '0;
    case (scheme_i)
      SCH_CONTACT:
      begin
        next_line.dplus_contact_source    = 1'b1;
        next_line.dminus_contact_pulldown = 1'b1;
      end
      SCH_PRIMARY:
      begin
        next_line.line_voltage_source = 1'b1;
        next_line.line_current_sink   = 1'b1;
      end
      SCH_SECONDARY:
      begin
        next_line.line_voltage_source = 1'b1;
        next_line.source_on_dminus    = 1'b1;
        next_line.line_current_sink   = 1'b1;
      end
      SCH_CDP:
      begin
        next_line.line_current_sink   = 1'b1;
        next_line.line_voltage_source = cdp_answer;
        next_line.source_on_dminus    = 1'b1;
      end
      SCH_DCP:   next_line.line_short_resistor = 1'b1;
      SCH_DIV27: next_line.divider_both        = 1'b1;
      SCH_V12:
      begin
        next_line.v12_on_dminus       = 1'b1;
        next_line.line_short_resistor = 1'b1;
      end
      default: next_line = '0;
    endcase
  end

  // cdp answer holds from d+ high until d+ low
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || scheme_i != SCH_CDP)
      cdp_answer <= 1'b0;
    else
      cdp_answer <= dp_high;
  end

  // registered line controls
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      line_o <= '0;
    else
      line_o <= next_line;
  end

  assign cdp_answer_o = cdp_answer;

  // cdp answer follows d+ level
  property p_cdp_follow;
    @(posedge sys_clk_i) disable iff (rst_i)
      (scheme_i == SCH_CDP && $past(scheme_i) == SCH_CDP && dp_high) |=> cdp_answer;
  endproperty
  a_cdp_follow: assert property (p_cdp_follow) else $error("cdp answer missing");

  // contact source and pulldown always together
  property p_contact_pair;
    @(posedge sys_clk_i) disable iff (rst_i)
      line_o.dplus_contact_source == line_o.dminus_contact_pulldown;
  endproperty
  a_contact_pair: assert property (p_contact_pair) else $error("contact pair split");

endmodule
`default_nettype wire

// [hdl/typec_role_and_charger_advert_ctrl.sv]
// Purpose: config channel role control and charger advertisement sequencing
// Assumes: analog comparators and adc codes synchronous to sys_clk_i
// Notes:   no register bus, control and status are plain ports
`timescale 1ns/10ps
`default_nettype none
`include "typec_ctrl_defines.svh"

module typec_role_and_charger_advert_ctrl
(
  // clock and reset
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_i,
  // role control
  input  wire typec_ctrl_pkg::port_role_t   role_cfg_i,
  input  wire logic                         swap_enable_i,
  input  wire logic                         swap_request_i,
  input  wire logic [1:0]                   cc_below_swap_threshold_i,
  input  wire logic [1:0]                   cc_connected_i,
  input  wire logic                         vbus_present_i,
  // dead battery and strap
  input  wire logic                         deadbatt_i,
  input  wire logic                         deadbatt_release_i,
  input  wire logic [9:0]                   bus_power_strap_code_i,
  input  wire logic                         strap_code_valid_i,
  input  wire logic                         ext_path_fault_i,
  // charger schemes
  input  wire typec_ctrl_pkg::line_scheme_t scheme_req_i,
  input  wire logic                         auto_dcp_i,
  input  wire typec_ctrl_pkg::line_scheme_t auto_detected_i,
  input  wire logic [9:0]                   dplus_code_i,
  // config channel controls
  output typec_ctrl_pkg::cc_ctrl_t          cc1_o,
  output typec_ctrl_pkg::cc_ctrl_t          cc2_o,
  // role status
  output logic                              is_source_o,
  output logic                              swap_detected_o,
  output logic                              attached_o,
  // start-up status
  output typec_ctrl_pkg::boot_mode_t        boot_mode_o,
  output logic                              boot_valid_o,
  output logic                              ext_sink_path_pin_o,
  // data line controls
  output typec_ctrl_pkg::line_ctrl_t        line_o,
  output logic                              adc_sample_req_o,
  output logic                              cdp_answer_o,
  output logic                              discharge_vbus_o,
  output typec_ctrl_pkg::line_scheme_t      active_scheme_o
);
  import typec_ctrl_pkg::*;

  //--------------------------------------------------
  // role control
  //--------------------------------------------------
  logic        source_role;
  logic        drp_phase;
  logic [31:0] drp_cnt;
  logic        drp_tick;
  logic        swap_sent;
  logic        swap_flag;
  logic        deadbatt_rd;
  logic        sink_now;
  logic        swap_rx;
  logic        swap_tx;

  // toggle timer end
  assign drp_tick = (drp_cnt == `DRP_HALF_CYC - 32'd1);
  // swap detect as sink, swap request as source
  assign swap_rx  = !source_role && swap_enable_i && (|(cc_below_swap_threshold_i & cc_connected_i));
  assign swap_tx  = source_role && swap_enable_i && swap_request_i && !swap_sent;
  // sink presentation, dual role phase or inverse of the power role
  assign sink_now = (role_cfg_i == ROLE_DUAL) ? !drp_phase : !source_role;

  // dual role toggle timer
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || role_cfg_i != ROLE_DUAL || drp_tick)
      drp_cnt <= 32'd0;
    else
      drp_cnt <= drp_cnt + 32'd1;
  end

  // dual role phase alternates each half period
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || role_cfg_i != ROLE_DUAL)
      drp_phase <= 1'b0;
    else if (drp_tick)
      drp_phase <= !drp_phase;
  end

  // power role, swaps move it both ways
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      source_role <= (role_cfg_i == ROLE_SOURCE); // fixed source starts as source
    else if (role_cfg_i == ROLE_DUAL)
      source_role <= drp_phase;
    else if (swap_rx)
      source_role <= 1'b1;
    else if (swap_sent && !swap_request_i)
      source_role <= 1'b0;
    else if (!swap_enable_i)
      source_role <= (role_cfg_i == ROLE_SOURCE);
  end

  // swap pulldown held while the core requests it
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !swap_enable_i || !source_role)
      swap_sent <= 1'b0;
    else if (swap_tx)
      swap_sent <= 1'b1;
    else if (!swap_request_i)
      swap_sent <= 1'b0;
  end

  // sticky swap flag to the core, set wins over clear
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      swap_flag <= 1'b0;
    else if (swap_rx)
      swap_flag <= 1'b1;
    else if (!swap_enable_i)
      swap_flag <= 1'b0;
  end

  // dead battery pulldown until firmware hands over
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      deadbatt_rd <= 1'b1;
    else if (deadbatt_release_i)
      deadbatt_rd <= 1'b0;
    else if (deadbatt_i)
      deadbatt_rd <= 1'b1;
  end

  // config channel pin controls, same for both pins except the swap pulldown, which follows cc_connected_i
  cc_ctrl_t next_cc1;
  cc_ctrl_t next_cc2;
  always_comb
  begin
    next_cc1                        = '0;
    next_cc1.pull_up                = !sink_now;
    next_cc1.deadbatt_sink_pulldown = sink_now && deadbatt_rd;
    next_cc1.trimmed_sink_pulldown  = sink_now && !deadbatt_rd;
    next_cc2                        = next_cc1;
    next_cc1.swap_signal_pulldown   = swap_sent && cc_connected_i[0];
    next_cc2.swap_signal_pulldown   = swap_sent && cc_connected_i[1];
  end

  // registered pin controls and role status
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cc1_o           <= '0;
      cc2_o           <= '0;
      is_source_o     <= 1'b0;
      swap_detected_o <= 1'b0;
      attached_o      <= 1'b0;
    end
    else
    begin
      cc1_o           <= next_cc1;
      cc2_o           <= next_cc2;
      is_source_o     <= source_role;
      swap_detected_o <= swap_flag;
      attached_o      <= !source_role && vbus_present_i;
    end
  end

  //--------------------------------------------------
  // start-up decision
  //--------------------------------------------------
  boot_mode_t next_boot;
  logic       boot_taken;

  // strap code decode
  assign next_boot = (bus_power_strap_code_i >= `STRAP_WAIT_LO) ? BOOT_WAIT_EXT :
                     (bus_power_strap_code_i <= `STRAP_SAFE_HI) ? BOOT_SAFE : BOOT_NORMAL;

  // first valid conversion after reset is kept
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      boot_taken  <= 1'b0;
      boot_mode_o <= BOOT_SAFE;
    end
    else if (strap_code_valid_i && !boot_taken)
    begin
      boot_taken  <= 1'b1;
      boot_mode_o <= next_boot;
    end
  end

  // external sink path pin for the wait option
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      ext_sink_path_pin_o <= 1'b0;
    else
      ext_sink_path_pin_o <= boot_taken && boot_mode_o == BOOT_WAIT_EXT
                             && !source_role && vbus_present_i && !ext_path_fault_i;
  end

  assign boot_valid_o = boot_taken;

  //--------------------------------------------------
  // charger scheme sequencing
  //--------------------------------------------------
  line_scheme_t want_scheme;
  line_scheme_t cur_scheme;
  logic [31:0]  gap_cnt;
  logic         in_gap;
  logic         auto_pick;

  // auto dcp follows the detected scheme among the three
  assign auto_pick   = auto_dcp_i && (auto_detected_i == SCH_DCP ||
                       auto_detected_i == SCH_DIV27 || auto_detected_i == SCH_V12);
  assign want_scheme = auto_dcp_i ? (auto_pick ? auto_detected_i : SCH_DCP)
                                  : scheme_req_i;

  // scheme change passes through an all-off gap
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cur_scheme <= SCH_OFF;
      gap_cnt    <= 32'd0;
      in_gap     <= 1'b0;
    end
    else if (in_gap)
    begin
      gap_cnt <= gap_cnt + 32'd1;
      if (gap_cnt == `SWITCH_GAP_CYC - 32'd1)
      begin
        in_gap     <= 1'b0;
        cur_scheme <= want_scheme;
      end
    end
    else if (want_scheme != cur_scheme)
    begin
      in_gap     <= 1'b1;
      gap_cnt    <= 32'd0;
      cur_scheme <= SCH_OFF;
    end
  end

  // data line driver
  line_scheme_driver u_lines
  (
    .sys_clk_i    (sys_clk_i),
    .rst_i        (rst_i),
    .scheme_i     (in_gap ? SCH_OFF : cur_scheme),
    .dplus_code_i (dplus_code_i),
    .line_o       (line_o),
    .cdp_answer_o (cdp_answer_o)
  );

  // adc sample request in detection phases
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      adc_sample_req_o <= 1'b0;
    else
      adc_sample_req_o <= !in_gap && (cur_scheme == SCH_PRIMARY
                          || cur_scheme == SCH_SECONDARY);
  end

  assign discharge_vbus_o = 1'b0;
  assign active_scheme_o  = cur_scheme;

  //--------------------------------------------------
  // checks
  //--------------------------------------------------
  property p_swap_turn_source;
    @(posedge sys_clk_i) disable iff (rst_i)
      (swap_rx && role_cfg_i != ROLE_DUAL) |=> ##1 (is_source_o && swap_detected_o);
  endproperty
  a_swap_turn_source: assert property (p_swap_turn_source) else $error("no swap to source");

  property p_swap_pulldown;
    @(posedge sys_clk_i) disable iff (rst_i)
      (swap_tx && cc_connected_i[0] && role_cfg_i != ROLE_DUAL) |=> ##1 cc1_o.swap_signal_pulldown;
  endproperty
  a_swap_pulldown: assert property (p_swap_pulldown) else $error("swap pulldown missing");

  property p_swap_pulldown_cc2;
    @(posedge sys_clk_i) disable iff (rst_i)
      (swap_tx && cc_connected_i[1] && role_cfg_i != ROLE_DUAL)
      |=> ##1 cc2_o.swap_signal_pulldown;
  endproperty
  a_swap_pulldown_cc2: assert property (p_swap_pulldown_cc2) else $error("no cc2 swap pd");

  property p_drp_toggle;
    @(posedge sys_clk_i) disable iff (rst_i)
      (role_cfg_i == ROLE_DUAL && drp_tick) |=> (drp_phase != $past(drp_phase));
  endproperty
  a_drp_toggle: assert property (p_drp_toggle) else $error("dual role did not toggle");

  property p_one_pulldown;
    @(posedge sys_clk_i) disable iff (rst_i)
      !(cc1_o.trimmed_sink_pulldown && cc1_o.deadbatt_sink_pulldown) && !(cc1_o.pull_up
      && (cc1_o.trimmed_sink_pulldown || cc1_o.deadbatt_sink_pulldown));
  endproperty
  a_one_pulldown: assert property (p_one_pulldown) else $error("cc presentation clash");

  property p_handover;
    @(posedge sys_clk_i) disable iff (rst_i)
      (deadbatt_release_i && sink_now) |=> ##1 !cc1_o.deadbatt_sink_pulldown;
  endproperty
  a_handover: assert property (p_handover) else $error("dead battery pulldown kept");

  property p_boot_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
      boot_taken |=> $stable(boot_mode_o);
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("start-up mode changed");

  property p_ext_pin;
    @(posedge sys_clk_i) disable iff (rst_i)
      ext_sink_path_pin_o |-> boot_mode_o == BOOT_WAIT_EXT;
  endproperty
  a_ext_pin: assert property (p_ext_pin) else $error("external pin without option");

  property p_gap_quiet;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!in_gap && want_scheme != cur_scheme) |=> ##1 (line_o == '0);
  endproperty
  a_gap_quiet: assert property (p_gap_quiet) else $error("lines not released");

  property p_attach;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!source_role && vbus_present_i) |=> attached_o;
  endproperty
  a_attach: assert property (p_attach) else $error("attach not shown");

endmodule
`default_nettype wire

// [testbench/usb_port_partner_model.sv]
// Purpose: attached port partner, drives cc level, vbus, d+ code and detection
// Assumes: commands from the bench change at the falling edge
// Notes:   d+ codes are random on each side of the 0.6 V level
`timescale 1ns/10ps
`default_nettype none

module usb_port_partner_model
(
  // clock
  input  wire logic                         sys_clk_i,
  // bench commands
  input  wire logic                         attach_i,
  input  wire logic [1:0]                   pull_low_i,
  input  wire logic                         dplus_high_i,
  input  wire typec_ctrl_pkg::line_scheme_t detect_i,
  // partner lines
  output logic                              vbus_present_o,
  output logic [1:0]                        cc_below_o,
  output logic [9:0]                        dplus_code_o,
  output typec_ctrl_pkg::line_scheme_t      auto_detected_o
);
  import typec_ctrl_pkg::*;
  // vbus follows the attach state, cc follows the pull-low command
  assign vbus_present_o  = attach_i;
  assign cc_below_o      = pull_low_i;
  assign auto_detected_o = detect_i;
  // d+ code is redrawn every cycle so no stale value lingers
  always @(negedge sys_clk_i)
  begin
    if (dplus_high_i)
      dplus_code_o <= 10'h0ba + 10'($urandom % 32'h345);
    else
      dplus_code_o <= 10'($urandom % 32'h0ba);
  end
endmodule
`default_nettype wire

// [testbench/typec_role_and_charger_advert_ctrl_test.sv]
// Purpose: self-checking bench for the connector role and charger control
// Assumes: inputs change at the falling edge
// Notes:   dual role check runs the full toggle half period
`timescale 1ns/10ps
`default_nettype none
`include "typec_ctrl_defines.svh"

module typec_role_and_charger_advert_ctrl_test;
  import typec_ctrl_pkg::*;
  logic         sys_clk_i = 1'b0;
  logic         rst_i = 1'b1;
  port_role_t   role = ROLE_SINK;
  logic         swap_en = 1'b0, swap_req = 1'b0, db = 1'b0, db_rel = 1'b0;
  logic         attach = 1'b0, dp_high = 1'b0, strap_v = 1'b0, fault = 1'b0, auto = 1'b0;
  logic [1:0]   conn = 2'b01, pull_low = 2'b00, cc_below;
  logic [9:0]   strap = 10'h000, dp_code;
  line_scheme_t req = SCH_OFF, detect = SCH_OFF, auto_det, act;
  logic         vbus, is_src, swp_det, att, boot_v, ext_pin, adc_req, cdp, dis;
  cc_ctrl_t     cc1, cc2;
  boot_mode_t   boot;
  line_ctrl_t   line;
  int           fails = 0, cmp_count = 0, n;

  always #2 sys_clk_i = ~sys_clk_i;

  usb_port_partner_model PARTNER (.sys_clk_i(sys_clk_i), .attach_i(attach),
    .pull_low_i(pull_low), .dplus_high_i(dp_high), .detect_i(detect),
    .vbus_present_o(vbus), .cc_below_o(cc_below), .dplus_code_o(dp_code),
    .auto_detected_o(auto_det));

  typec_role_and_charger_advert_ctrl DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .role_cfg_i(role), .swap_enable_i(swap_en), .swap_request_i(swap_req),
    .cc_below_swap_threshold_i(cc_below), .cc_connected_i(conn), .vbus_present_i(vbus),
    .deadbatt_i(db), .deadbatt_release_i(db_rel), .bus_power_strap_code_i(strap),
    .strap_code_valid_i(strap_v), .ext_path_fault_i(fault), .scheme_req_i(req),
    .auto_dcp_i(auto), .auto_detected_i(auto_det), .dplus_code_i(dp_code),
    .cc1_o(cc1), .cc2_o(cc2), .is_source_o(is_src), .swap_detected_o(swp_det),
    .attached_o(att), .boot_mode_o(boot), .boot_valid_o(boot_v),
    .ext_sink_path_pin_o(ext_pin), .line_o(line), .adc_sample_req_o(adc_req),
    .cdp_answer_o(cdp), .discharge_vbus_o(dis), .active_scheme_o(act));

  // expected data line controls of each scheme
  function automatic line_ctrl_t line_exp(line_scheme_t s);
    case (s)
      SCH_CONTACT:   return 8'hc0;
      SCH_PRIMARY:   return 8'h28;
      SCH_SECONDARY: return 8'h38;
      SCH_CDP:       return 8'h18;
      SCH_DCP:       return 8'h04;
      SCH_DIV27:     return 8'h02;
      SCH_V12:       return 8'h05;
      default:       return 8'h00;
    endcase
  endfunction

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(negedge sys_clk_i);
  endtask

  task automatic do_reset();
    rst_i = 1'b1;
    cyc(6);
    rst_i = 1'b0;
  endtask

  // request a scheme, check the quiet gap, then the applied controls
  task automatic run_scheme(line_scheme_t s, line_scheme_t e);
    req = s;
    cyc(2);
    chk("gap line", 16'h0, 16'(line));
    n = 0;
    while (act !== e && n < 400)
    begin
      cyc(1);
      n++;
    end
    chk("scheme", 16'(e), 16'(act));
    cyc(3);
    chk("line", 16'(line_exp(e)), 16'(line));
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #(4 * 60000);
    fails++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(32'hf0e7));
    do_reset();
    chk("boot reset", 16'(BOOT_SAFE), 16'(boot));
    cyc(3);
    chk("cc1 deadbatt", 16'h2, 16'(cc1));
    chk("cc2 deadbatt", 16'h2, 16'(cc2));
    attach = 1'b1;
    cyc(3);
    chk("attached", 16'h1, 16'(att));
    db_rel = 1'b1;
    cyc(1);
    db_rel = 1'b0;
    cyc(3);
    chk("cc1 trimmed", 16'h4, 16'(cc1));
    // strap caught once, later codes ignored
    strap = 10'h300 + 10'($urandom % 32'h100);
    strap_v = 1'b1;
    cyc(1);
    strap_v = 1'b0;
    strap = 10'h000;
    cyc(1);
    chk("boot valid", 16'h1, 16'(boot_v));
    chk("boot mode", 16'(BOOT_WAIT_EXT), 16'(boot));
    strap_v = 1'b1;
    cyc(1);
    strap_v = 1'b0;
    cyc(2);
    chk("boot kept", 16'(BOOT_WAIT_EXT), 16'(boot));
    chk("ext pin", 16'h1, 16'(ext_pin));
    fault = 1'b1;
    cyc(2);
    chk("ext pin fault", 16'h0, 16'(ext_pin));
    fault = 1'b0;
    // every scheme but off and cdp in turn, then cdp against the d+ level
    for (int i = 1; i < 8; i++)
      if (i != 4)
        run_scheme(line_scheme_t'(i), line_scheme_t'(i));
    run_scheme(SCH_PRIMARY, SCH_PRIMARY);
    n = 0;
    while (adc_req !== 1'b1 && n < 300)
    begin
      cyc(1);
      n++;
    end
    chk("adc sample", 16'h1, 16'(adc_req));
    run_scheme(SCH_CDP, SCH_CDP);
    chk("cdp idle", 16'h0, 16'(cdp));
    dp_high = 1'b1;
    cyc(3);
    chk("cdp answer", 16'h1, 16'(cdp));
    chk("cdp d- source", 16'h1, 16'(line.line_voltage_source));
    dp_high = 1'b0;
    cyc(3);
    chk("cdp released", 16'h0, 16'(cdp));
    // automatic scheme follows the attached device
    auto = 1'b1;
    req = SCH_DCP;
    for (int k = 0; k < 3; k++)
    begin
      detect = k == 0 ? SCH_DIV27 : (k == 1 ? SCH_V12 : SCH_DCP);
      run_scheme(SCH_DCP, detect);
      chk("no discharge", 16'h0, 16'(dis));
    end
    auto = 1'b0;
    // sink to source on a low cc
    swap_en = 1'b1;
    pull_low = 2'b01;
    cyc(3);
    chk("swap flag", 16'h1, 16'(swp_det));
    chk("now source", 16'h1, 16'(is_src));
    chk("pull up", 16'h1, 16'(cc1.pull_up));
    pull_low = 2'b00;
    // source to sink on a core request
    role = ROLE_SOURCE;
    conn = 2'b10;
    do_reset();
    cyc(4);
    chk("source", 16'h1, 16'(is_src));
    swap_req = 1'b1;
    cyc(3);
    chk("swap pulldown", 16'h1, 16'(cc2.swap_signal_pulldown));
    swap_req = 1'b0;
    cyc(3);
    chk("now sink", 16'h0, 16'(is_src));
    // dual role half period
    role = ROLE_DUAL;
    for (int t = 0; t < 2; t++)
    begin
      automatic logic p = cc1.pull_up;
      n = 0;
      while (cc1.pull_up === p && n < 9000)
      begin
        cyc(1);
        n++;
      end
      chk("both pins", 16'(cc1.pull_up), 16'(cc2.pull_up));
      if (t == 1)
        chk("half period", 16'(`DRP_HALF_CYC), 16'(n));
    end
    print_verdict();
  end
endmodule
`default_nettype wire
